// ===== src/ofs_cfg_pkg.sv
package ofs_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int DATA_OUT_W = 14;
    localparam logic [7:0] ADDR_HIGH_PERF_A = 8'h02;
    localparam logic [7:0] ADDR_CHAN_B_PED = 8'hc1;
    localparam logic [7:0] ADDR_LOOP_CTRL = 8'hcf;
    localparam logic [7:0] ADDR_HIGH_PERF_B = 8'hd5;
    localparam logic [7:0] ADDR_HIGH_PERF_C = 8'hd7;
    localparam logic [7:0] ADDR_HP_CHB_SLOW = 8'hdb;
    localparam logic [7:0] ADDR_SLOW_MASTER = 8'hef;
    localparam logic [7:0] ADDR_SWING_EN = 8'hf1;
    localparam logic [7:0] ADDR_CHAN_A_SLOW = 8'hf2;
    // host-side controls, each given its own address here
    localparam logic [7:0] ADDR_OFFSET_EN = 8'h3d;
    localparam logic [7:0] ADDR_DIGITAL_EN = 8'h42;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int PED_MSB = 7;
    localparam int PED_LSB = 2;
    localparam int HOLD_BIT = 7;
    localparam int TAU_MSB = 5;
    localparam int TAU_LSB = 2;
    localparam int SLOW_MASTER_BIT = 4;
    localparam int CHA_SLOW_BIT = 3;
    localparam int CHB_SLOW_BIT = 0;
    localparam int TUNE3_BIT = 6;
    localparam int TUNE4_BIT = 4;
    localparam int TUNE5_BIT = 3;
    localparam int TUNE6_BIT = 3;
    localparam int TUNE7_BIT = 2;
    localparam int TUNE8_BIT = 5;
    localparam int OFFSET_EN_BIT = 5;
    localparam int DIGITAL_EN_BIT = 3;
    localparam int SWING_MSB = 1;
    localparam int SWING_LSB = 0;
    localparam logic [1:0] SWING_OFF = 2'h0;
    localparam logic [1:0] SWING_ON = 2'h3;
    localparam logic [13:0] MIDCODE = 14'h2000;
    localparam int ACC_W = 32;
    localparam int ACC_FRAC = 16;
    localparam int SHIFT_MIN = 4;
endpackage : ofs_cfg_pkg

// ===== src/offset_loop.sv
`timescale 1ns/1ps
`default_nettype none
module offset_loop
    import ofs_cfg_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic sys_rst, // sync reset
    input wire logic run, // loop enabled
    input wire logic hold, // freeze estimate
    input wire logic [3:0] tau, // time-constant code
    input wire logic signed [5:0] ped, // signed pedestal
    input wire logic [13:0] raw, // raw converter sample
    output logic [13:0] corrected // corrected sample
);
    typedef struct packed {
        logic signed [ACC_W-1:0] acc;
        logic [13:0] out;
    } st_s;
    st_s st, next_st;
    logic signed [ACC_W-1:0] target, err, est;
    logic [4:0] shamt;
    always_comb
    begin
        next_st = st;
        // fixed table: averaging length 2^(tau+4) cycles
        shamt = 5'(tau) + 5'(SHIFT_MIN);
        target = ACC_W'(signed'({1'b0, MIDCODE})) + ACC_W'(ped);
        est = st.acc >>> ACC_FRAC;
        err = ACC_W'(signed'({1'b0, raw})) - est - target;
        if (run && !hold) // RL4 RL18
        begin
            next_st.acc = st.acc + ((err <<< ACC_FRAC) >>> shamt);
        end
        if (run) // RL2 RL15
        begin
            next_st.out = 14'(ACC_W'(signed'({1'b0, raw})) - est);
        end
        else
        begin
            next_st.out = raw;
        end
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end
    assign corrected = st.out;
endmodule : offset_loop
`default_nettype wire

// ===== src/offset_mode_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// RL1: pedestal field is signed, -32 to +31
// RL2: loop converges channel B to midcode plus pedestal
// RL3: each channel has own pedestal register
// RL4: freeze holds last offset estimate
// RL5: host keeps correction enabled when using freeze
// RL6: time constant from control bits five..two
// RL7: master bit gates per-channel low-speed enables
// RL8: channel A low-speed from its bit three
// RL9: channel B low-speed from bit zero
// RL10: host sets master before per-channel bits
// RL11: swing control off at 00, on at 11
// RL12: host sets all tune bits above 160 MSPS
// RL13: tune bits sit at documented addresses
// RL14: all registers reset to zero
// RL15: correction runs only with enable bit set
// RL16: digital enable gates all digital functions
// RL17: host writes zero to reserved bits
// RL18: time-constant code maps by fixed table
module offset_mode_regs
    import ofs_cfg_pkg::*;
(
    input wire logic clk, // 100 MHz clock
    input wire logic sys_rst, // sync reset, high
    input wire logic [ADDR_W-1:0] addr, // register address
    input wire logic [DATA_W-1:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [13:0] chan_b_raw, // channel B raw sample
    output logic [DATA_W-1:0] rdata, // read data, cycle after rd
    output logic [13:0] chan_b_data, // channel B corrected sample
    output logic signed [5:0] chan_b_offset_shift, // pedestal value
    output logic hold_offset_estimate, // freeze control
    output logic [3:0] offset_loop_tau, // loop time-constant code
    output logic offset_loop_enable, // effective correction enable
    output logic chan_a_slow_en, // channel A low-speed active
    output logic chan_b_slow_en, // channel B low-speed active
    output logic swing_reg_ctrl, // swing under register control
    output logic [5:0] fast_rate_tune // tune bits 3..8 in [0..5]
);
    typedef struct packed {
        logic [7:0] high_perf_ctrl_a;
        logic [7:0] chan_b_offset_pedestal;
        logic [7:0] offset_loop_control;
        logic [7:0] high_perf_ctrl_b;
        logic [7:0] high_perf_ctrl_c;
        logic [7:0] high_perf_and_chan_b_slow;
        logic [7:0] slow_mode_master;
        logic [7:0] swing_control_enable;
        logic [7:0] chan_a_slow_mode;
        logic [7:0] offset_en_reg;
        logic [7:0] digital_en_reg;
        logic [7:0] rdata;
    } regs_s;
    regs_s r, next_r;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction : hit

    // one decode shared by the unmapped-read check and its coverage
    function automatic logic mapped(input logic [7:0] a);
        case (a)
            ADDR_HIGH_PERF_A, ADDR_CHAN_B_PED, ADDR_LOOP_CTRL, ADDR_HIGH_PERF_B,
            ADDR_HIGH_PERF_C, ADDR_HP_CHB_SLOW, ADDR_SLOW_MASTER, ADDR_SWING_EN,
            ADDR_CHAN_A_SLOW, ADDR_OFFSET_EN, ADDR_DIGITAL_EN: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : mapped

    always_comb
    begin
        next_r = r;
        next_r.rdata = RESET_VALUE;
        if (wr)
        begin
            if (hit(addr, ADDR_HIGH_PERF_A)) next_r.high_perf_ctrl_a = wdata; // RL13
            if (hit(addr, ADDR_CHAN_B_PED)) next_r.chan_b_offset_pedestal = wdata; // RL3
            if (hit(addr, ADDR_LOOP_CTRL)) next_r.offset_loop_control = wdata;
            if (hit(addr, ADDR_HIGH_PERF_B)) next_r.high_perf_ctrl_b = wdata;
            if (hit(addr, ADDR_HIGH_PERF_C)) next_r.high_perf_ctrl_c = wdata;
            if (hit(addr, ADDR_HP_CHB_SLOW)) next_r.high_perf_and_chan_b_slow = wdata;
            if (hit(addr, ADDR_SLOW_MASTER)) next_r.slow_mode_master = wdata;
            if (hit(addr, ADDR_SWING_EN)) next_r.swing_control_enable = wdata;
            if (hit(addr, ADDR_CHAN_A_SLOW)) next_r.chan_a_slow_mode = wdata;
            if (hit(addr, ADDR_OFFSET_EN)) next_r.offset_en_reg = wdata;
            if (hit(addr, ADDR_DIGITAL_EN)) next_r.digital_en_reg = wdata;
        end
        if (rd)
        begin
            // unmapped addresses read zero
            case (addr)
                ADDR_HIGH_PERF_A: next_r.rdata = r.high_perf_ctrl_a;
                ADDR_CHAN_B_PED: next_r.rdata = r.chan_b_offset_pedestal;
                ADDR_LOOP_CTRL: next_r.rdata = r.offset_loop_control;
                ADDR_HIGH_PERF_B: next_r.rdata = r.high_perf_ctrl_b;
                ADDR_HIGH_PERF_C: next_r.rdata = r.high_perf_ctrl_c;
                ADDR_HP_CHB_SLOW: next_r.rdata = r.high_perf_and_chan_b_slow;
                ADDR_SLOW_MASTER: next_r.rdata = r.slow_mode_master;
                ADDR_SWING_EN: next_r.rdata = r.swing_control_enable;
                ADDR_CHAN_A_SLOW: next_r.rdata = r.chan_a_slow_mode;
                ADDR_OFFSET_EN: next_r.rdata = r.offset_en_reg;
                ADDR_DIGITAL_EN: next_r.rdata = r.digital_en_reg;
                default: next_r.rdata = RESET_VALUE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            r <= '0; // RL14
        else
            r <= next_r;
    end

    assign rdata = r.rdata;
    assign chan_b_offset_shift = signed'(r.chan_b_offset_pedestal[PED_MSB:PED_LSB]); // RL1
    assign hold_offset_estimate = r.offset_loop_control[HOLD_BIT];
    assign offset_loop_tau = r.offset_loop_control[TAU_MSB:TAU_LSB]; // RL6
    // correction needs both its own bit and the digital master
    assign offset_loop_enable = r.offset_en_reg[OFFSET_EN_BIT] // RL15
        && r.digital_en_reg[DIGITAL_EN_BIT]; // RL16
    assign chan_a_slow_en = r.slow_mode_master[SLOW_MASTER_BIT] // RL7
        && r.chan_a_slow_mode[CHA_SLOW_BIT]; // RL8
    assign chan_b_slow_en = r.slow_mode_master[SLOW_MASTER_BIT]
        && r.high_perf_and_chan_b_slow[CHB_SLOW_BIT]; // RL9
    // codes 01 and 10 are forbidden; treated as off
    assign swing_reg_ctrl = r.swing_control_enable[SWING_MSB:SWING_LSB] == SWING_ON; // RL11
    assign fast_rate_tune = {r.high_perf_and_chan_b_slow[TUNE8_BIT], // RL13
        r.high_perf_ctrl_c[TUNE7_BIT], r.high_perf_ctrl_c[TUNE6_BIT],
        r.high_perf_ctrl_b[TUNE5_BIT], r.high_perf_ctrl_b[TUNE4_BIT],
        r.high_perf_ctrl_a[TUNE3_BIT]};

    offset_loop u_loop (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(offset_loop_enable), // RL5
        .hold(hold_offset_estimate), // RL4
        .tau(offset_loop_tau),
        .ped(chan_b_offset_shift), // RL2
        .raw(chan_b_raw),
        .corrected(chan_b_data)
    );

    property p_reset_zero;
        @(posedge clk) sys_rst |=> (r == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("registers not zero after reset"); // RL14

    property p_slow_master;
        @(posedge clk) disable iff (sys_rst)
        !r.slow_mode_master[SLOW_MASTER_BIT] |-> !chan_a_slow_en && !chan_b_slow_en;
    endproperty
    a_slow_master: assert property (p_slow_master) else $error("slow mode without master"); // RL7

    property p_cha_slow;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_CHAN_A_SLOW) && r.slow_mode_master[SLOW_MASTER_BIT]
            && !(hit(addr, ADDR_SLOW_MASTER))
        |=> chan_a_slow_en == $past(wdata[CHA_SLOW_BIT]);
    endproperty
    a_cha_slow: assert property (p_cha_slow) else $error("channel A slow mismatch"); // RL8

    property p_chb_slow;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_HP_CHB_SLOW) && r.slow_mode_master[SLOW_MASTER_BIT]
        |=> chan_b_slow_en == $past(wdata[CHB_SLOW_BIT]);
    endproperty
    a_chb_slow: assert property (p_chb_slow) else $error("channel B slow mismatch"); // RL9

    property p_ped_sign;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_CHAN_B_PED) ##1 1
        |-> (chan_b_offset_shift < 0) == $past(wdata[PED_MSB]);
    endproperty
    a_ped_sign: assert property (p_ped_sign) else $error("pedestal sign wrong"); // RL1

    property p_tau;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_LOOP_CTRL) |=> offset_loop_tau == $past(wdata[TAU_MSB:TAU_LSB]);
    endproperty
    a_tau: assert property (p_tau) else $error("time constant not taken"); // RL6

    property p_swing;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_SWING_EN)
        |=> swing_reg_ctrl == ($past(wdata[SWING_MSB:SWING_LSB]) == SWING_ON);
    endproperty
    a_swing: assert property (p_swing) else $error("swing control on for wrong code"); // RL11

    property p_digital;
        @(posedge clk) disable iff (sys_rst)
        !r.digital_en_reg[DIGITAL_EN_BIT] || !r.offset_en_reg[OFFSET_EN_BIT]
        |=> chan_b_data == $past(chan_b_raw);
    endproperty
    a_digital: assert property (p_digital) else $error("correction active while disabled"); // RL15

    property p_tune3;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_HIGH_PERF_A) |=> fast_rate_tune[0] == $past(wdata[TUNE3_BIT]);
    endproperty
    a_tune3: assert property (p_tune3) else $error("tune bit 3 misplaced"); // RL13

    property p_read;
        @(posedge clk) disable iff (sys_rst)
        rd && hit(addr, ADDR_SLOW_MASTER) && !wr |=> rdata == r.slow_mode_master;
    endproperty
    a_read: assert property (p_read) else $error("readback mismatch");

    // read data stands one cycle only, unmapped reads give zero
    property p_rdata_idle;
        @(posedge clk) disable iff (sys_rst)
        !rd |=> rdata == RESET_VALUE;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

    property p_unmapped_rd;
        @(posedge clk) disable iff (sys_rst)
        rd && !mapped(addr) |=> rdata == RESET_VALUE;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

    property p_read_ped;
        @(posedge clk) disable iff (sys_rst)
        rd && hit(addr, ADDR_CHAN_B_PED) |=> rdata == $past(r.chan_b_offset_pedestal);
    endproperty
    a_read_ped: assert property (p_read_ped) else $error("pedestal readback wrong"); // RL3

    // pedestal and loop controls
    property p_ped_value;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_CHAN_B_PED)
        |=> chan_b_offset_shift == signed'($past(wdata[PED_MSB:PED_LSB]));
    endproperty
    a_ped_value: assert property (p_ped_value) else $error("pedestal value wrong"); // RL1

    // another address must never disturb the channel B pedestal
    property p_ped_isolated;
        @(posedge clk) disable iff (sys_rst)
        wr && !hit(addr, ADDR_CHAN_B_PED) |=> $stable(chan_b_offset_shift);
    endproperty
    a_ped_isolated: assert property (p_ped_isolated) else $error("pedestal disturbed"); // RL3

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_LOOP_CTRL) |=> hold_offset_estimate == $past(wdata[HOLD_BIT]);
    endproperty
    a_hold: assert property (p_hold) else $error("freeze bit not taken"); // RL4

    property p_freeze;
        @(posedge clk) disable iff (sys_rst)
        offset_loop_enable && hold_offset_estimate |=> $stable(u_loop.st.acc);
    endproperty
    a_freeze: assert property (p_freeze) else $error("estimate moved while frozen"); // RL4

    // correction enables
    property p_run;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_OFFSET_EN) && r.digital_en_reg[DIGITAL_EN_BIT]
        |=> offset_loop_enable == $past(wdata[OFFSET_EN_BIT]);
    endproperty
    a_run: assert property (p_run) else $error("correction enable not taken"); // RL15

    property p_digital_off;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_DIGITAL_EN) && !wdata[DIGITAL_EN_BIT] |=> !offset_loop_enable;
    endproperty
    a_digital_off: assert property (p_digital_off) else $error("digital master ignored"); // RL16

    // low-speed gating
    property p_master_on;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_SLOW_MASTER) && wdata[SLOW_MASTER_BIT]
        |=> chan_a_slow_en == r.chan_a_slow_mode[CHA_SLOW_BIT]
            && chan_b_slow_en == r.high_perf_and_chan_b_slow[CHB_SLOW_BIT];
    endproperty
    a_master_on: assert property (p_master_on) else $error("channel bits not followed"); // RL7

    property p_chb_off;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_HP_CHB_SLOW) && !wdata[CHB_SLOW_BIT] |=> !chan_b_slow_en;
    endproperty
    a_chb_off: assert property (p_chb_off) else $error("channel B slow stuck on"); // RL9

    property p_cha_off;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_CHAN_A_SLOW) && !wdata[CHA_SLOW_BIT] |=> !chan_a_slow_en;
    endproperty
    a_cha_off: assert property (p_cha_off) else $error("channel A slow stuck on"); // RL8

    // code 00 always leaves register swing control off
    property p_swing_off;
        @(posedge clk) disable iff (sys_rst)
        r.swing_control_enable[SWING_MSB:SWING_LSB] == SWING_OFF |-> !swing_reg_ctrl;
    endproperty
    a_swing_off: assert property (p_swing_off) else $error("swing control on at code 00"); // RL11

    property p_tune4;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_HIGH_PERF_B) |=> fast_rate_tune[1] == $past(wdata[TUNE4_BIT]);
    endproperty
    a_tune4: assert property (p_tune4) else $error("tune bit 4 misplaced"); // RL13

    property p_tune5;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_HIGH_PERF_B) |=> fast_rate_tune[2] == $past(wdata[TUNE5_BIT]);
    endproperty
    a_tune5: assert property (p_tune5) else $error("tune bit 5 misplaced"); // RL13

    property p_tune6;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_HIGH_PERF_C) |=> fast_rate_tune[3] == $past(wdata[TUNE6_BIT]);
    endproperty
    a_tune6: assert property (p_tune6) else $error("tune bit 6 misplaced"); // RL13

    property p_tune7;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_HIGH_PERF_C) |=> fast_rate_tune[4] == $past(wdata[TUNE7_BIT]);
    endproperty
    a_tune7: assert property (p_tune7) else $error("tune bit 7 misplaced"); // RL13

    property p_tune8;
        @(posedge clk) disable iff (sys_rst)
        wr && hit(addr, ADDR_HP_CHB_SLOW) |=> fast_rate_tune[5] == $past(wdata[TUNE8_BIT]);
    endproperty
    a_tune8: assert property (p_tune8) else $error("tune bit 8 misplaced"); // RL13

    // enable, freeze, swing, tune and read outputs start off after reset
    property p_reset_out;
        @(posedge clk)
        sys_rst |=> !offset_loop_enable && !hold_offset_estimate && !swing_reg_ctrl
            && fast_rate_tune == '0 && rdata == RESET_VALUE;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not off after reset"); // RL14

    property p_reset_data;
        @(posedge clk)
        sys_rst |=> chan_b_data == '0;
    endproperty
    a_reset_data: assert property (p_reset_data) else $error("sample not cleared by reset"); // RL14

    c_freeze: cover property (@(posedge clk) offset_loop_enable && hold_offset_estimate);
    c_slow_both: cover property (@(posedge clk) chan_a_slow_en && chan_b_slow_en);
    c_swing: cover property (@(posedge clk) swing_reg_ctrl);
    c_tune_all: cover property (@(posedge clk) &fast_rate_tune);
    c_unmapped_rd: cover property (@(posedge clk) rd && !mapped(addr));
endmodule : offset_mode_regs
`default_nettype wire

// ===== dv/cfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_host
    import ofs_cfg_pkg::*;
(
    input wire logic clk, // system clock
    output logic [ADDR_W-1:0] addr, // register address
    output logic [DATA_W-1:0] wdata, // write data
    output logic wr, // write strobe
    output logic rd // read strobe
);
    initial
    begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // strobe stays up across back-to-back calls so no signal is set twice per edge
    task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask : put
    task automatic idle();
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask : idle
endmodule : cfg_host
`default_nettype wire

// ===== dv/test_adc_offset_mode_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_offset_mode_config_regs
    import ofs_cfg_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [13:0] chan_b_raw = 14'h0000;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, rd_seen = 1'b0;
    logic [13:0] chan_b_data, v;
    logic signed [5:0] shift;
    logic hold, loop_en, a_slow, b_slow, swing;
    logic [3:0] tau;
    logic [5:0] tune;
    logic [20:0] ctl;
    logic [7:0] exp_q[$];
    logic [7:0] regs[11];
    logic [31:0] seed = 32'hf8ba;
    int error_cnt = 0;
    int n_compared = 0;
    assign ctl = {shift, hold, tau, loop_en, a_slow, b_slow, swing, tune};
    cfg_host host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    offset_mode_regs dut_u (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .chan_b_raw(chan_b_raw), .rdata(rdata),
        .chan_b_data(chan_b_data), .chan_b_offset_shift(shift),
        .hold_offset_estimate(hold), .offset_loop_tau(tau), .offset_loop_enable(loop_en),
        .chan_a_slow_en(a_slow), .chan_b_slow_en(b_slow), .swing_reg_ctrl(swing),
        .fast_rate_tune(tune));
    initial
    begin
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // reserved bits kept zero except digital enable bits 7..3, swing code only 00 or 11
    function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] x);
        case (a)
            ADDR_HIGH_PERF_A: return x & 8'h40;
            ADDR_CHAN_B_PED: return x & 8'hfc;
            ADDR_LOOP_CTRL: return x & 8'hbc;
            ADDR_HIGH_PERF_B: return x & 8'h18;
            ADDR_HIGH_PERF_C: return x & 8'h0c;
            ADDR_HP_CHB_SLOW: return x & 8'h21;
            ADDR_SLOW_MASTER: return x & 8'h10;
            ADDR_SWING_EN: return {6'h00, {2{x[0]}}};
            ADDR_CHAN_A_SLOW: return x & 8'h08;
            ADDR_OFFSET_EN: return x & 8'h20;
            default: return x & 8'hf8;
        endcase
    endfunction : legal
    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected rdata at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_rd
    task automatic cmp_out(input logic [20:0] got, input logic [20:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected output at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_out
    task automatic wrx(input logic [7:0] a, input logic [7:0] dd);
        host_u.put(1'b1, a, dd);
    endtask : wrx
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.put(1'b0, a, 8'h00);
    endtask : rdx
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // read data stands only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rd_seen)
            cmp_rd(rdata, exp_q.pop_front());
        rd_seen <= rd;
    end
    initial
    begin
        #100_000;
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        regs = '{ADDR_HIGH_PERF_A, ADDR_CHAN_B_PED, ADDR_LOOP_CTRL, ADDR_HIGH_PERF_B,
            ADDR_HIGH_PERF_C, ADDR_HP_CHB_SLOW, ADDR_SLOW_MASTER, ADDR_SWING_EN,
            ADDR_CHAN_A_SLOW, ADDR_OFFSET_EN, ADDR_DIGITAL_EN};
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 cmp_out(ctl, 21'h0);
        for (int i = 0; i < 11; i++)
            rdx(regs[i], 8'h00);
        for (int i = 0; i < 11; i++)
        begin
            seed = lfsr(seed);
            wrx(regs[i], legal(regs[i], seed[7:0]));
        end
        wrx(8'h55, 8'hff);
        seed = 32'hf8ba;
        for (int i = 0; i < 11; i++)
        begin
            seed = lfsr(seed);
            rdx(regs[i], legal(regs[i], seed[7:0]));
        end
        rdx(8'h55, 8'h00);
        host_u.idle();
        host_u.idle();
        $display("test reset and readback done");
        for (int i = 0; i < 4; i++)
        begin
            // codes 0, +31, -32 and -1
            d = {i[1], {5{i[0]}}, 2'b00};
            wrx(ADDR_CHAN_B_PED, d);
            #1 cmp_out(21'(shift), 21'($signed(d[7:2])));
        end
        for (int t = 0; t < 16; t++)
        begin
            wrx(ADDR_LOOP_CTRL, {t[0], 1'b0, 4'(t), 2'b00});
            #1 cmp_out(21'({hold, tau}), 21'({t[0], 4'(t)}));
        end
        for (int i = 0; i < 8; i++)
        begin
            wrx(ADDR_SLOW_MASTER, {3'b000, i[2], 4'h0});
            wrx(ADDR_CHAN_A_SLOW, {4'h0, i[1], 3'b000});
            wrx(ADDR_HP_CHB_SLOW, {7'h00, i[0]});
            #1 cmp_out(21'({a_slow, b_slow}), 21'({i[2] & i[1], i[2] & i[0]}));
        end
        wrx(ADDR_SWING_EN, 8'h00);
        #1 cmp_out(21'(swing), 21'h0);
        wrx(ADDR_SWING_EN, 8'h03);
        #1 cmp_out(21'(swing), 21'h1);
        for (int k = 0; k < 6; k++)
        begin
            wrx(ADDR_HIGH_PERF_A, k == 0 ? 8'h40 : 8'h00);
            wrx(ADDR_HIGH_PERF_B, {3'b000, k == 1, k == 2, 3'b000});
            wrx(ADDR_HIGH_PERF_C, {4'h0, k == 3, k == 4, 2'b00});
            wrx(ADDR_HP_CHB_SLOW, k == 5 ? 8'h20 : 8'h00);
            #1 cmp_out(21'(tune), 21'(6'h01 << k));
        end
        wrx(ADDR_HIGH_PERF_A, 8'h40);
        wrx(ADDR_HIGH_PERF_B, 8'h18);
        wrx(ADDR_HIGH_PERF_C, 8'h0c);
        wrx(ADDR_HP_CHB_SLOW, 8'h21);
        #1 cmp_out(21'(tune), 21'h3f);
        for (int i = 0; i < 4; i++)
        begin
            wrx(ADDR_OFFSET_EN, {2'b00, i[1], 5'h00});
            wrx(ADDR_DIGITAL_EN, {4'h0, i[0], 3'b000});
            #1 cmp_out(21'(loop_en), 21'(i[1] & i[0]));
        end
        $display("test field decodes done");
        chan_b_raw <= 14'h2100;
        wrx(ADDR_CHAN_B_PED, 8'hec);
        wrx(ADDR_LOOP_CTRL, 8'h00);
        wrx(ADDR_OFFSET_EN, 8'h20);
        wrx(ADDR_DIGITAL_EN, 8'h08);
        host_u.idle();
        repeat (3000) @(posedge clk);
        // fractional accumulator may leave one code of ripple
        #1 cmp_out(21'(chan_b_data >= 14'h1ffa && chan_b_data <= 14'h1ffc), 21'h1);
        v = chan_b_data;
        wrx(ADDR_LOOP_CTRL, 8'h80);
        chan_b_raw <= 14'h2140;
        host_u.idle();
        repeat (20) @(posedge clk);
        #1 cmp_out(21'(chan_b_data), 21'(v + 14'h0040));
        wrx(ADDR_DIGITAL_EN, 8'h00);
        host_u.idle();
        repeat (3) @(posedge clk);
        #1 cmp_out(21'(chan_b_data), 21'(14'h2140));
        $display("test offset loop done");
        tally_and_finish();
    end
endmodule : test_adc_offset_mode_config_regs
`default_nettype wire
